// [rtl/tsic_consts.vh]
`ifndef TSIC_CONSTS_VH
`define TSIC_CONSTS_VH
// Register byte offsets on the AXI4-Lite slave.
`define TSIC_REG_CTRL 8'h00
`define TSIC_REG_STATUS 8'h04
`define TSIC_REG_KEYS 8'h08
`define TSIC_REG_CURSOR 8'h0c
// Control register fields.
`define TSIC_CTRL_HOLD 0
`define TSIC_CTRL_PRINTER 1
`define TSIC_CTRL_SCROLL 2
// Identification progress codes (octal values in hex).
`define TSIC_ID_IDLE 8'h00
`define TSIC_ID_REQ 8'h5d
`define TSIC_ID_ESC 8'h1b
`define TSIC_ID_SLASH 8'h2f
`define TSIC_ID_TYPE 8'h41
// Character codes.
`define TSIC_CH_ESC 8'h1b
`define TSIC_CH_SLASH 8'h2f
`define TSIC_CH_Z 8'h5a
`define TSIC_CH_LF 8'h0a
`define TSIC_CH_XON 8'h11
`define TSIC_CH_XOFF 8'h13
// Screen geometry and timing.
`define TSIC_LAST_ROW 5'h17
`define TSIC_CLK_HZ 100000000
`define TSIC_FRAME_HZ 60
`define TSIC_FRAME_CYCLES (`TSIC_CLK_HZ / `TSIC_FRAME_HZ)
`endif

// [rtl/tsic_fifo.v]
`timescale 1ns/1ps
`include "tsic_consts.vh"
module tsic_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset.
	input wire clk,
	input wire reset,
	// Fill side.
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	// Drain side.
	output reg [WIDTH-1:0] out_data,
	output reg out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	wire load;

	// The output register is refilled whenever it is empty or being taken.
	assign in_ready = ({{(31-AW){1'b0}}, count} != DEPTH);
	assign push = in_valid && in_ready;
	assign load = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);
	assign pop = load;

	// Storage and pointers; the output word is registered for timing.
	always @(posedge clk) begin
		if (reset) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
			out_data <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				out_data <= mem[rd_ptr];
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

// [rtl/tsic_top.v]
`timescale 1ns/1ps
`include "tsic_consts.vh"
// Summary of operation
// - Keys are scanned once per frame at 60 passes a second and a pressed key is recorded in one of two held slots.
// - Each pass first re-tests both held keys and sends nothing if they are still down.
// - A held key found released has its slot cleared and a fresh search for new keys follows.
// - A line feed on the bottom row scrolls the screen, dropping the top row and blanking the bottom row.
// - Scrolling advances the top-row pointer by one with wrap instead of copying rows.
// - The top-row pointer ranges over 0 to 23 and is zero after reset.
// - The cursor row is kept both as a stored-row address and as an on-screen row address.
// - In hold mode a bottom-row line feed is parked instead of scrolling, and XOFF is sent.
// - Characters that arrive after XOFF are buffered in the silo and not displayed.
// - The scroll key in hold mode performs the parked scroll and then drains the silo in order.
// - When the silo has drained, XON is sent and reception resumes until the next parked line feed.
// - An ESC Z request is answered with escape, slash and a type letter that depends on the printer option.
// - At most one reply character goes out per frame, and reply progress is remembered.
// - The reply progress state uses the codes 0, 135, 033, 057 and 101 octal.
// - Keyboard scanning is suspended while a reply is in progress.
module tsic_top #(
	parameter FRAME_CYCLES = `TSIC_FRAME_CYCLES,
	parameter KEY_MAX = 7'h4f,
	parameter [7:0] TYPE_PLAIN = 8'h41,
	parameter [7:0] TYPE_PRINTER = 8'h42
) (
	// Clock and reset.
	input wire clk,
	input wire reset,
	// AXI4-Lite slave.
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Keyboard matrix probe.
	output reg [6:0] key_probe,
	input wire key_down,
	// Host serial channel, receive side.
	input wire [7:0] host_rx_data,
	input wire host_rx_valid,
	output reg host_rx_ready,
	// Host serial channel, transmit side.
	output reg [7:0] host_tx_data,
	output reg host_tx_valid,
	input wire host_tx_ready,
	// Display control.
	output reg [4:0] top_row,
	output reg [4:0] cursor_stored_row,
	output reg [4:0] cursor_screen_row,
	output reg [7:0] disp_data,
	output reg disp_valid,
	output reg blank_row_pulse,
	output reg [4:0] blank_row
);
	// Scan state codes.
	localparam S_IDLE = 5'b00001;
	localparam S_TESTA = 5'b00010;
	localparam S_TESTB = 5'b00100;
	localparam S_SEARCH = 5'b01000;
	localparam S_SEND = 5'b10000;

	reg [31:0] frame_cnt;
	reg frame_tick;
	reg [4:0] scan_state;
	reg [6:0] slot_a;
	reg [6:0] slot_b;
	reg [6:0] search_key;
	reg [7:0] ident_progress_state;
	reg hold_mode;
	reg printer_fitted;
	reg lf_parked;
	reg draining;
	reg silo_push_d;
	reg xon_due;
	reg xoff_due;
	reg esc_seen;
	reg [7:0] key_code;
	reg key_due;
	reg [31:0] keys_sent;
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	wire [7:0] silo_out;
	wire silo_out_valid;
	wire silo_in_ready;
	wire silo_push;
	wire silo_take;
	wire tx_free;
	wire [7:0] cur_ch;
	wire cur_valid;
	wire scroll_cmd;
	wire wr_fire;

	////////////////////////////////////////////////////////////////////////////////
	// Frame divider: one enable pulse per displayed frame.

	always @(posedge clk) begin
		if (reset) begin
			frame_cnt <= 32'h0;
			frame_tick <= 1'b0;
		end else if (frame_cnt == FRAME_CYCLES - 1) begin
			frame_cnt <= 32'h0;
			frame_tick <= 1'b1;
		end else begin
			frame_cnt <= frame_cnt + 32'h1;
			frame_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host input path. Parked characters go to the silo; the silo feeds the
	// interpreter while draining. Reception stalls whenever the silo is full,
	// which is the only protection against a host that ignores XOFF.

	assign silo_push = host_rx_valid && host_rx_ready && (lf_parked || draining);
	assign cur_valid = draining ? silo_out_valid : (host_rx_valid && host_rx_ready && !lf_parked);
	assign cur_ch = draining ? silo_out : host_rx_data;
	assign silo_take = draining && !lf_parked;

	tsic_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) silo (
		.clk(clk),
		.reset(reset),
		.in_data(host_rx_data),
		.in_valid(silo_push),
		.in_ready(silo_in_ready),
		.out_data(silo_out),
		.out_valid(silo_out_valid),
		.out_ready(silo_take)
	);

	assign tx_free = !host_tx_valid || host_tx_ready;
	assign wr_fire = aw_held && w_held;
	assign scroll_cmd = wr_fire && (aw_addr == `TSIC_REG_CTRL) && w_strb[0] && w_data[`TSIC_CTRL_SCROLL];

	////////////////////////////////////////////////////////////////////////////////
	// Character interpreter, scroll and hold control.

	always @(posedge clk) begin
		if (reset) begin
			top_row <= 5'h0;
			cursor_stored_row <= 5'h0;
			cursor_screen_row <= 5'h0;
			lf_parked <= 1'b0;
			draining <= 1'b0;
			silo_push_d <= 1'b0;
			xoff_due <= 1'b0;
			xon_due <= 1'b0;
			esc_seen <= 1'b0;
			disp_valid <= 1'b0;
			disp_data <= 8'h0;
			blank_row_pulse <= 1'b0;
			blank_row <= 5'h0;
			host_rx_ready <= 1'b0;
		end else begin
			disp_valid <= 1'b0;
			blank_row_pulse <= 1'b0;
			// A word pushed last cycle is not yet visible at the silo output.
			silo_push_d <= silo_push;
			host_rx_ready <= silo_in_ready && !(host_rx_valid && host_rx_ready);
			if (hold_mode && lf_parked && scroll_cmd) begin
				lf_parked <= 1'b0;
				draining <= 1'b1;
				blank_row <= top_row;
				blank_row_pulse <= 1'b1;
				top_row <= (top_row == `TSIC_LAST_ROW) ? 5'h0 : top_row + 5'h1;
				cursor_stored_row <= top_row;
			end else if (draining && !lf_parked && !silo_out_valid && !silo_push && !silo_push_d) begin
				draining <= 1'b0;
				xon_due <= 1'b1;
			end
			if (cur_valid && !(hold_mode && lf_parked && scroll_cmd)) begin
				esc_seen <= (cur_ch == `TSIC_CH_ESC);
				if (esc_seen && cur_ch == `TSIC_CH_Z) begin
					esc_seen <= 1'b0;
				end else if (cur_ch == `TSIC_CH_LF) begin
					if (cursor_screen_row != `TSIC_LAST_ROW) begin
						cursor_screen_row <= cursor_screen_row + 5'h1;
						cursor_stored_row <= (cursor_stored_row == `TSIC_LAST_ROW) ? 5'h0
							: cursor_stored_row + 5'h1;
					end else if (hold_mode) begin
						lf_parked <= 1'b1;
						xoff_due <= 1'b1;
					end else begin
						// Advancing the pointer instead of copying rows; old top becomes bottom.
						blank_row <= top_row;
						blank_row_pulse <= 1'b1;
						top_row <= (top_row == `TSIC_LAST_ROW) ? 5'h0 : top_row + 5'h1;
						cursor_stored_row <= top_row;
					end
				end else if (cur_ch != `TSIC_CH_ESC) begin
					disp_data <= cur_ch;
					disp_valid <= 1'b1;
				end
			end
			// Clears mirror the transmit arbiter exactly, so each flow-control char goes out once.
			if (xoff_due && tx_free && ident_progress_state == `TSIC_ID_IDLE) begin
				xoff_due <= 1'b0;
			end else if (xon_due && !xoff_due && tx_free && ident_progress_state == `TSIC_ID_IDLE) begin
				xon_due <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Identification reply, one character per frame.

	always @(posedge clk) begin
		if (reset) begin
			ident_progress_state <= `TSIC_ID_IDLE;
		end else if (cur_valid && esc_seen && cur_ch == `TSIC_CH_Z && ident_progress_state == `TSIC_ID_IDLE) begin
			ident_progress_state <= `TSIC_ID_REQ;
		end else if (frame_tick && tx_free) begin
			case (ident_progress_state)
				`TSIC_ID_REQ: ident_progress_state <= `TSIC_ID_ESC;
				`TSIC_ID_ESC: ident_progress_state <= `TSIC_ID_SLASH;
				`TSIC_ID_SLASH: ident_progress_state <= `TSIC_ID_TYPE;
				`TSIC_ID_TYPE: ident_progress_state <= `TSIC_ID_IDLE;
				default: ident_progress_state <= `TSIC_ID_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit arbitration: reply characters, then flow control, then keys.

	always @(posedge clk) begin
		if (reset) begin
			host_tx_valid <= 1'b0;
			host_tx_data <= 8'h0;
		end else if (tx_free) begin
			host_tx_valid <= 1'b0;
			if (frame_tick && ident_progress_state == `TSIC_ID_REQ) begin
				host_tx_data <= `TSIC_CH_ESC;
				host_tx_valid <= 1'b1;
			end else if (frame_tick && ident_progress_state == `TSIC_ID_ESC) begin
				host_tx_data <= `TSIC_CH_SLASH;
				host_tx_valid <= 1'b1;
			end else if (frame_tick && ident_progress_state == `TSIC_ID_SLASH) begin
				host_tx_data <= printer_fitted ? TYPE_PRINTER : TYPE_PLAIN;
				host_tx_valid <= 1'b1;
			end else if (ident_progress_state == `TSIC_ID_IDLE && xoff_due) begin
				host_tx_data <= `TSIC_CH_XOFF;
				host_tx_valid <= 1'b1;
			end else if (ident_progress_state == `TSIC_ID_IDLE && xon_due) begin
				host_tx_data <= `TSIC_CH_XON;
				host_tx_valid <= 1'b1;
			end else if (ident_progress_state == `TSIC_ID_IDLE && key_due) begin
				host_tx_data <= key_code;
				host_tx_valid <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Keyboard scan. Each pass probes one key per cycle, held slots first.
	// Key numbers are sent as codes directly; translation is left to software.

	always @(posedge clk) begin
		if (reset) begin
			scan_state <= S_IDLE;
			slot_a <= 7'h0;
			slot_b <= 7'h0;
			search_key <= 7'h0;
			key_probe <= 7'h0;
			key_code <= 8'h0;
			key_due <= 1'b0;
			keys_sent <= 32'h0;
		end else begin
			if (key_due && tx_free && ident_progress_state == `TSIC_ID_IDLE && !xoff_due && !xon_due) begin
				key_due <= 1'b0;
				keys_sent <= keys_sent + 32'h1;
			end
			case (scan_state)
				S_IDLE: begin
					if (frame_tick && ident_progress_state == `TSIC_ID_IDLE && !key_due) begin
						scan_state <= S_TESTA;
						key_probe <= slot_a;
					end
				end
				S_TESTA: begin
					if (slot_a != 7'h0 && !key_down) begin
						slot_a <= 7'h0;
					end
					scan_state <= S_TESTB;
					key_probe <= slot_b;
				end
				S_TESTB: begin
					if (slot_b != 7'h0 && !key_down) begin
						slot_b <= 7'h0;
					end
					if (slot_a != 7'h0 && slot_b != 7'h0 && key_down) begin
						scan_state <= S_IDLE;
					end else begin
						scan_state <= S_SEARCH;
						search_key <= KEY_MAX;
						key_probe <= KEY_MAX;
					end
				end
				S_SEARCH: begin
					if (search_key == 7'h0) begin
						scan_state <= S_IDLE;
					end else if (key_down && search_key != slot_a && search_key != slot_b) begin
						scan_state <= S_SEND;
					end else begin
						search_key <= search_key - 7'h1;
						key_probe <= search_key - 7'h1;
					end
				end
				S_SEND: begin
					if (slot_a == 7'h0) begin
						slot_a <= search_key;
					end else begin
						slot_b <= search_key;
					end
					key_code <= {1'b0, search_key};
					key_due <= 1'b1;
					scan_state <= S_IDLE;
				end
				default: scan_state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave. Address and data are caught in either order; the
	// write completes once both are held.

	always @(posedge clk) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			hold_mode <= 1'b0;
			printer_fitted <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[7:2] == 6'h0) ? 2'h0 : 2'h2;
				if (aw_addr == `TSIC_REG_CTRL && w_strb[0]) begin
					hold_mode <= w_data[`TSIC_CTRL_HOLD];
					printer_fitted <= w_data[`TSIC_CTRL_PRINTER];
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read side answers one cycle after the address is taken.
	always @(posedge clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					`TSIC_REG_CTRL: s_axi_rdata <= {30'h0, printer_fitted, hold_mode};
					`TSIC_REG_STATUS: s_axi_rdata <= {8'h0, ident_progress_state, 8'h0,
						3'h0, !silo_in_ready, silo_out_valid, xon_due, draining, lf_parked};
					`TSIC_REG_KEYS: s_axi_rdata <= {2'h0, keys_sent[15:0], 7'h0, slot_b[6:0]} ^
						{18'h0, slot_a, 7'h0};
					`TSIC_REG_CURSOR: s_axi_rdata <= {16'h0, top_row, 1'b0, cursor_screen_row, cursor_stored_row};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// [dv/tsic_properties.sv]
`timescale 1ns/1ps
// Watches scroll, cursor and host-channel ports of the control block.
module tsic_properties (
	// Clock and reset.
	input wire clk,
	input wire reset,
	// Display state.
	input wire [4:0] top_row,
	input wire [4:0] cursor_stored_row,
	input wire [4:0] cursor_screen_row,
	input wire blank_row_pulse,
	input wire [4:0] blank_row,
	input wire disp_valid,
	// Host channel.
	input wire [7:0] host_tx_data,
	input wire host_tx_valid,
	input wire host_tx_ready,
	input wire host_rx_valid,
	input wire host_rx_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// The row that leaves the top becomes the blank bottom row, one below in wrap order.
	function automatic [4:0] row_before(input [4:0] r);
		row_before = (r == 5'h00) ? 5'h17 : r - 5'h01;
	endfunction

	// Stored row is top row plus screen row, modulo 24.
	function automatic [4:0] stored_of(input [4:0] t, input [4:0] s);
		reg [5:0] sum;
		sum = {1'b0, t} + {1'b0, s};
		stored_of = (sum > 6'h17) ? sum[4:0] - 5'h18 : sum[4:0];
	endfunction

	////////////////////////////////////////////////////////////////
	// Scroll pointer.
	AST_TOP_RANGE: assert property (top_row <= 5'h17) else $error("top row out of range");
	AST_TOP_CLEARED: assert property ($past(reset) |-> top_row == 5'h00) else $error("top row not zero");
	AST_SCROLL_STEP: assert property ($changed(top_row) && !$past(reset) |->
		top_row == (($past(top_row) == 5'h17) ? 5'h00 : $past(top_row) + 5'h01)) else $error("bad scroll step");
	AST_BLANK_ROW: assert property (blank_row_pulse |->
		(blank_row == row_before(top_row)) || (blank_row == $past(top_row))) else $error("wrong row blanked");
	// The two cursor rows only have to agree once all three have settled.
	AST_ROW_MAP: assert property ($stable(top_row) && $stable(cursor_screen_row) && $stable(cursor_stored_row) |->
		cursor_stored_row == stored_of(top_row, cursor_screen_row)) else $error("cursor rows disagree");
	AST_SCREEN_RANGE: assert property (cursor_screen_row <= 5'h17 && cursor_stored_row <= 5'h17)
		else $error("cursor row out of range");

	////////////////////////////////////////////////////////////////
	// Host channel handshakes.
	AST_TX_STANDS: assert property (host_tx_valid && !host_tx_ready |=> host_tx_valid && $stable(host_tx_data))
		else $error("transmit char dropped");
	AST_RX_SPACING: assert property (host_rx_valid && host_rx_ready |=> !host_rx_ready)
		else $error("receive taken twice");

	COV_SCROLL: cover property (blank_row_pulse);
	COV_TX: cover property (host_tx_valid && host_tx_ready);
	COV_DISP: cover property (disp_valid);
	COV_SILO_FULL: cover property (host_rx_valid && !host_rx_ready);
endmodule

bind tsic_top tsic_properties tsic_properties_i (.clk(clk), .reset(reset), .top_row(top_row),
	.cursor_stored_row(cursor_stored_row), .cursor_screen_row(cursor_screen_row),
	.blank_row_pulse(blank_row_pulse), .blank_row(blank_row), .disp_valid(disp_valid),
	.host_tx_data(host_tx_data), .host_tx_valid(host_tx_valid), .host_tx_ready(host_tx_ready),
	.host_rx_valid(host_rx_valid), .host_rx_ready(host_rx_ready));

// [dv/tsic_host_model.sv]
`timescale 1ns/1ps
`include "tsic_consts.vh"
// Host processor on the serial channel: sends queued chars, collects replies.
module tsic_host_model (
	// Clock and reset.
	input wire clk,
	input wire reset,
	// Chars towards the terminal.
	output reg [7:0] rx_data,
	output reg rx_valid,
	input wire rx_ready,
	// Chars from the terminal.
	input wire [7:0] tx_data,
	input wire tx_valid,
	output reg tx_ready
);
	reg [7:0] sendq[$];
	reg [7:0] got[$];
	time stamp[$];
	reg slow = 1'b0;
	integer grace = -1;
	integer ph = 0;

	// A stopped host still lets a few chars slip out, like a real one with a buffer.
	always @(posedge clk) begin
		if (reset) begin
			rx_valid <= 1'b0;
			rx_data <= 8'hff;
			tx_ready <= 1'b0;
		end else begin
			ph <= ph + 1;
			tx_ready <= slow ? ph[1] : 1'b1;
			if (tx_valid && tx_ready) begin
				got.push_back(tx_data);
				stamp.push_back($time);
				if (tx_data == `TSIC_CH_XOFF)
					grace <= 20;
				if (tx_data == `TSIC_CH_XON)
					grace <= -1;
			end
			// Released data shows the inverse so a stale value never matches.
			if (rx_valid && rx_ready) begin
				rx_valid <= 1'b0;
				rx_data <= ~rx_data;
			end else if (!rx_valid && sendq.size() > 0 && grace != 0) begin
				rx_data <= sendq.pop_front();
				rx_valid <= 1'b1;
				if (grace > 0)
					grace <= grace - 1;
			end
		end
	end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
`include "tsic_consts.vh"
module testbench;
	localparam FC = 400;
	reg clk = 1'b0;
	reg reset = 1'b1;
	reg [7:0] awaddr = 8'h00, araddr = 8'h00;
	reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	reg [31:0] wdata = 32'h0, rd;
	reg [1:0] rs;
	reg [6:0] ka = 7'h7f, kb = 7'h7f;
	wire awready, wready, bvalid, arready, rvalid, rx_valid, rx_ready, tx_valid, tx_ready;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [6:0] key_probe;
	wire [7:0] rx_data, tx_data, disp_data;
	wire [4:0] top_row, cursor_stored_row, cursor_screen_row, blank_row;
	wire disp_valid, blank_row_pulse;
	integer num_errors = 0, n_checks = 0, cyc = 0, nblank = 0;
	reg [4:0] last_blank;
	reg [7:0] dq[$];
	// Only the probed key answers, so the scan must walk the matrix to find it.
	wire key_down = (key_probe === ka) || (key_probe === kb);

	tsic_top #(.FRAME_CYCLES(FC)) tsic_top_i (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.key_probe(key_probe), .key_down(key_down), .host_rx_data(rx_data), .host_rx_valid(rx_valid),
		.host_rx_ready(rx_ready), .host_tx_data(tx_data), .host_tx_valid(tx_valid), .host_tx_ready(tx_ready),
		.top_row(top_row), .cursor_stored_row(cursor_stored_row), .cursor_screen_row(cursor_screen_row),
		.disp_data(disp_data), .disp_valid(disp_valid), .blank_row_pulse(blank_row_pulse), .blank_row(blank_row));
	tsic_host_model tsic_host_model_i (.clk(clk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////
	// Display monitor and hang guard; line feeds are not printable chars.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (disp_valid && disp_data !== `TSIC_CH_LF)
			dq.push_back(disp_data);
		if (blank_row_pulse) begin
			nblank = nblank + 1;
			last_blank = blank_row;
		end
		if (cyc == 40000) begin
			num_errors = num_errors + 1;
			final_report;
		end
	end

	task chk(input [31:0] got, input [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			num_errors = num_errors + 1;
		end
	endtask

	task final_report;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Each channel is released at the edge that takes it; bready stands until the answer.
	task axw(input [7:0] a, input [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task axr(input [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task frames(input integer n);
		repeat (n * FC) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios.
	task t_reset;
		chk(top_row, 32'h0);
		chk(cursor_stored_row, 32'h0);
		axr(`TSIC_REG_CURSOR);
		chk(rd, 32'h0);
		axr(8'h40);
		chk(rs, 32'h2);
		axw(`TSIC_REG_STATUS, 32'h0);
		chk(rs, 32'h2);
	endtask

	// The higher key goes second so the downward search meets it first.
	task t_keys;
		tsic_host_model_i.got.delete();
		ka <= 7'h05;
		frames(3);
		chk(tsic_host_model_i.got.size(), 32'h1);
		kb <= 7'h4f;
		frames(3);
		chk(tsic_host_model_i.got.size(), 32'h2);
		chk(tsic_host_model_i.got[1], 32'h4f);
		ka <= 7'h7f;
		kb <= 7'h7f;
		frames(2);
		ka <= 7'h05;
		frames(3);
		chk(tsic_host_model_i.got.size(), 32'h3);
		chk(tsic_host_model_i.got[2], 32'h05);
		ka <= 7'h7f;
		frames(2);
		axr(`TSIC_REG_KEYS);
		chk(rd, 32'h0000c000);
	endtask

	task t_ident(input p);
		integer i;
		axw(`TSIC_REG_CTRL, {30'h0, p, 1'b0});
		tsic_host_model_i.slow = p;
		tsic_host_model_i.got.delete();
		tsic_host_model_i.stamp.delete();
		tsic_host_model_i.sendq.push_back(`TSIC_CH_ESC);
		tsic_host_model_i.sendq.push_back(`TSIC_CH_Z);
		i = 0;
		while (tsic_host_model_i.got.size() < 1 && i < 4 * FC) begin
			@(posedge clk);
			i = i + 1;
		end
		axr(`TSIC_REG_STATUS);
		chk(rd[23:16], `TSIC_ID_ESC);
		kb <= 7'h07;
		frames(6);
		chk(tsic_host_model_i.got.size(), 32'h4);
		chk(tsic_host_model_i.got[0], `TSIC_CH_ESC);
		chk(tsic_host_model_i.got[1], `TSIC_CH_SLASH);
		chk(tsic_host_model_i.got[2], p ? 32'h42 : 32'h41);
		chk(tsic_host_model_i.got[3], 32'h07);
		chk(tsic_host_model_i.stamp[2] - tsic_host_model_i.stamp[1] >= FC * 5, 32'h1);
		axr(`TSIC_REG_STATUS);
		chk(rd[23:16], `TSIC_ID_IDLE);
		kb <= 7'h7f;
		frames(2);
	endtask

	// Hold mode parks the line feed, then seventeen chars fill the silo.
	task t_scroll;
		integer i;
		for (i = 0; i < 24; i = i + 1)
			tsic_host_model_i.sendq.push_back(`TSIC_CH_LF);
		repeat (150) @(posedge clk);
		chk(top_row, 32'h1);
		chk(nblank, 32'h1);
		chk(last_blank, 32'h0);
		chk(cursor_screen_row, 32'h17);
		chk(cursor_stored_row, 32'h0);
		axw(`TSIC_REG_CTRL, 32'h1);
		tsic_host_model_i.got.delete();
		dq.delete();
		tsic_host_model_i.sendq.push_back(`TSIC_CH_LF);
		for (i = 0; i < 17; i = i + 1)
			tsic_host_model_i.sendq.push_back(8'h41 + i[7:0]);
		repeat (150) @(posedge clk);
		chk(top_row, 32'h1);
		chk(tsic_host_model_i.got[0], `TSIC_CH_XOFF);
		chk(dq.size(), 32'h0);
		axr(`TSIC_REG_STATUS);
		chk(rd[4] & rd[0], 32'h1);
		axw(`TSIC_REG_CTRL, 32'h5);
		repeat (400) @(posedge clk);
		chk(top_row, 32'h2);
		chk(dq.size(), 32'h11);
		for (i = 0; i < 17; i = i + 1)
			chk(dq[i], 32'h41 + i);
		chk(tsic_host_model_i.got[tsic_host_model_i.got.size() - 1], `TSIC_CH_XON);
		axr(`TSIC_REG_STATUS);
		chk(rd[4:0], 32'h0);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset;
		t_keys;
		t_ident(1'b0);
		t_ident(1'b1);
		t_scroll;
		final_report;
	end
endmodule
